/* uecs_host_model.sv */
`default_nettype none
module uecs_host_model
   import uecs_pkg::*;
(
   // system
   input wire logic clk,
   // in link
   output logic inPktSent,
   output logic inAckRcvd,
   output logic sofRcvd,
   // out link
   output logic outToken,
   output logic outPktValid,
   output logic [COUNT_W-1:0] outPktLen,
   output logic outPktCrcErr,
   input wire logic outStall
);
   timeunit 1ns;
   timeprecision 1ns;
   int stallCnt = 0;
   initial begin
      {inPktSent, inAckRcvd, sofRcvd, outToken, outPktValid, outPktCrcErr} = '0;
      outPktLen = '0;
   end
   task automatic inEvt(input logic sent, input logic ack, input logic sof);
      @(posedge clk);
      inPktSent <= sent;
      inAckRcvd <= ack;
      sofRcvd <= sof;
      @(posedge clk);
      {inPktSent, inAckRcvd, sofRcvd} <= '0;
   endtask
   // token first; no data follows a stalled token
   task automatic outPkt(input logic [COUNT_W-1:0] len, input logic crc);
      @(posedge clk);
      outToken <= 1'b1;
      @(posedge clk);
      outToken <= 1'b0;
      if (outStall === 1'b1) stallCnt++;
      else begin
         outPktValid <= 1'b1;
         outPktLen <= len;
         outPktCrcErr <= crc;
      end
      @(posedge clk);
      outPktValid <= 1'b0;
      outPktLen <= ~len;
      outPktCrcErr <= ~crc;
   endtask
endmodule // uecs_host_model
`default_nettype wire

/* uecs_monitor.sv */
`default_nettype none
module uecs_monitor
   import uecs_pkg::*;
(
   // system
   input wire logic clk,
   input wire logic rst,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   // link
   input wire logic inPktSent,
   input wire logic inAckRcvd,
   input wire logic inPktReady,
   input wire logic inToggle,
   input wire logic outToken,
   input wire logic outPktValid,
   input wire logic outStall,
   input wire logic outAccept,
   // config and irq
   input wire logic inDirActive,
   input wire logic outDirActive,
   input wire logic fifoSplit,
   input wire logic inIrq,
   input wire logic outIrq
);
   wire logic apbWr = psel && penable && pwrite;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   AST_STALL_CAUSE: assert property (outStall |-> outToken && outDirActive)
      else $error("stall without token");
   AST_STALL_NAK: assert property (outStall |-> !outAccept)
      else $error("halted endpoint accepts data");
   AST_SPLIT_DIRS: assert property (fifoSplit |-> inDirActive && outDirActive)
      else $error("split fifo lost a direction");
   AST_ONE_DIR: assert property (!fifoSplit |-> inDirActive ^ outDirActive)
      else $error("direction select wrong");
   AST_IN_READY: assert property (inPktReady |-> inDirActive)
      else $error("in packet offered on out endpoint");
   AST_IN_IRQ_CAUSE: assert property ($rose(inIrq) |-> $past(inPktSent) || $past(apbWr))
      else $error("in irq without send");
   AST_OUT_IRQ_CAUSE: assert property ($rose(outIrq) |-> $past(outPktValid)
      || $past(outPktValid, 2) || $past(outStall) || $past(apbWr) || $past(apbWr, 3)
      || $past(apbWr, 2)) else $error("out irq without cause");
   AST_IRQ_HELD: assert property (outIrq && !apbWr |=> outIrq)
      else $error("out irq dropped unserviced");
   AST_IN_TOGGLE: assert property ($changed(inToggle) |-> $past(inPktSent)
      || $past(inAckRcvd) || $past(apbWr)) else $error("toggle moved alone");
   COV_STALL: cover property (outStall);
   COV_IN_IRQ: cover property ($rose(inIrq));
   COV_OUT_IRQ: cover property ($rose(outIrq));
endmodule // uecs_monitor
`default_nettype wire

/* uecs_pkg.sv */
`default_nettype none
package uecs_pkg;
   // register indices; byte address is four times the index
   localparam logic [5:0] IDX_IRQ_STATUS = 6'h02;
   localparam logic [5:0] IDX_IRQ_ENABLE = 6'h07;
   localparam logic [5:0] IDX_EP_OPTIONS = 6'h08;
   localparam logic [5:0] IDX_IN_CTRL_LOW = 6'h11;
   localparam logic [5:0] IDX_IN_CTRL_HIGH = 6'h12;
   localparam logic [5:0] IDX_OUT_CTRL_LOW = 6'h14;
   localparam logic [5:0] IDX_OUT_CTRL_HIGH = 6'h15;
   localparam logic [5:0] IDX_OUT_COUNT_LOW = 6'h16;
   localparam logic [5:0] IDX_OUT_COUNT_HIGH = 6'h17;

   // in_ctrl_low fields
   localparam int IN_LOADED_BIT = 0;
   localparam int IN_HAS_PKT_BIT = 1;
   localparam int IN_CLR_TOGGLE_BIT = 6;
   // in_ctrl_high fields
   localparam int IN_DBL_BIT = 7;
   localparam int ISO_BIT = 6;
   localparam int DIR_BIT = 5;
   localparam int FORCE_TGL_BIT = 3;
   localparam int SPLIT_BIT = 2;
   // out_ctrl_low fields
   localparam int OUT_WAITING_BIT = 0;
   localparam int OUT_FULL_BIT = 1;
   localparam int OUT_NO_ROOM_BIT = 2;
   localparam int OUT_CRC_BIT = 3;
   localparam int OUT_FLUSH_BIT = 4;
   localparam int OUT_HALT_REQ_BIT = 5;
   localparam int OUT_HALT_SENT_BIT = 6;
   localparam int OUT_CLR_TOGGLE_BIT = 7;
   // out_ctrl_high fields
   localparam int OUT_DBL_BIT = 7;
   // options and interrupt fields
   localparam int SOF_WAIT_BIT = 0;
   localparam int IRQ_IN_BIT = 0;
   localparam int IRQ_OUT_BIT = 1;

   // sticky flag slots
   localparam int FLAG_HALT_SENT = 0;
   localparam int FLAG_NO_ROOM = 1;
   localparam int FLAG_IN_PEND = 2;
   localparam int FLAG_OUT_PEND = 3;
   localparam int FLAG_COUNT = 4;

   localparam int COUNT_W = 10;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [1:0] SLOTS_SINGLE = 2'h1;
   localparam logic [1:0] SLOTS_DOUBLE = 2'h2;

   typedef enum logic [3:0] {
      UECS_NONE, UECS_IRQ_STATUS, UECS_IRQ_ENABLE, UECS_OPTIONS, UECS_IN_LOW,
      UECS_IN_HIGH, UECS_OUT_LOW, UECS_OUT_HIGH, UECS_CNT_LOW, UECS_CNT_HIGH
   } uecs_reg_t;
endpackage
`default_nettype wire

/* uecs_slot_counter.sv */
`default_nettype none
module uecs_slot_counter
   import uecs_pkg::*;
(
   // system
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // control
   input wire logic dual,
   input wire logic push,
   input wire logic pop,
   // status
   output logic [1:0] count,
   output logic hasRoom,
   output logic notEmpty
);
   logic doPush;
   logic doPop;

   assign hasRoom = count < (dual ? SLOTS_DOUBLE : SLOTS_SINGLE);
   assign notEmpty = count != 2'h0;
   assign doPush = push & hasRoom;
   assign doPop = pop & notEmpty;

   always_ff @(posedge clk) begin
      if (rst) begin
         count <= 2'h0;
      end else if (ce) begin
         if (doPush && !doPop) begin
            count <= count + 2'h1;
         end else if (doPop && !doPush) begin
            count <= count - 2'h1;
         end
      end
   end
endmodule // uecs_slot_counter
`default_nettype wire

/* uecs_sticky_flags.sv */
`default_nettype none
module uecs_sticky_flags
   import uecs_pkg::*;
(
   // system
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // events and clears
   input wire logic [FLAG_COUNT-1:0] setVec,
   input wire logic [FLAG_COUNT-1:0] clrVec,
   // flags
   output logic [FLAG_COUNT-1:0] flags
);
   genvar i;
   generate
      for (i = 0; i < FLAG_COUNT; i++) begin : g_flag
         // a set in the clearing cycle wins
         always_ff @(posedge clk) begin
            if (rst) begin
               flags[i] <= 1'b0;
            end else if (ce) begin
               if (setVec[i]) begin
                  flags[i] <= 1'b1;
               end else if (clrVec[i]) begin
                  flags[i] <= 1'b0;
               end
            end
         end
      end
   endgenerate
endmodule // uecs_sticky_flags
`default_nettype wire

/* uecs_top.sv */
`default_nettype none
// Behaviour
// - loaded clears on send or open slot
// - iso sof-wait: loaded reads 0 until SOF
// - in interrupt on hardware clear after send
// - fifo-has-packet shows in fifo occupancy
// - high bit 7 enables in double buffering
// - high bit 6 selects isochronous transfers
// - bit 5 direction, only without split
// - bit 3 forces toggle flip per packet
// - bit 2 splits fifo between directions
// - bits 4, 1:0 read zero, ignore writes
// - out interrupt on waiting set or stall
// - bulk out packet sets waiting, interrupts
// - byte count of head packet readable
// - halt request stalls every out token while out direction active
// - each stall sets sticky flag and interrupts
// - second queued packet re-sets waiting flag
// - iso packet stored, waiting set, interrupt
// - iso packet without room sets overrun
// - iso crc error stored and flagged
module uecs_top
   import uecs_pkg::*;
(
   // system
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // in endpoint link
   input wire logic inPktSent,
   input wire logic inAckRcvd,
   input wire logic sofRcvd,
   output logic inPktReady,
   output logic inToggle,
   // out endpoint link
   input wire logic outToken,
   input wire logic outPktValid,
   input wire logic [COUNT_W-1:0] outPktLen,
   input wire logic outPktCrcErr,
   output logic outStall,
   output logic outAccept,
   output logic outToggle,
   // endpoint configuration
   output logic inDirActive,
   output logic outDirActive,
   output logic fifoSplit,
   // interrupt requests
   output logic inIrq,
   output logic outIrq
);
   function automatic uecs_reg_t uecs_decode(input logic [7:0] addr);
      uecs_reg_t sel;
      sel = UECS_NONE;
      if (addr[1:0] == 2'h0) begin
         case (addr[7:2])
            IDX_IRQ_STATUS: sel = UECS_IRQ_STATUS;
            IDX_IRQ_ENABLE: sel = UECS_IRQ_ENABLE;
            IDX_EP_OPTIONS: sel = UECS_OPTIONS;
            IDX_IN_CTRL_LOW: sel = UECS_IN_LOW;
            IDX_IN_CTRL_HIGH: sel = UECS_IN_HIGH;
            IDX_OUT_CTRL_LOW: sel = UECS_OUT_LOW;
            IDX_OUT_CTRL_HIGH: sel = UECS_OUT_HIGH;
            IDX_OUT_COUNT_LOW: sel = UECS_CNT_LOW;
            IDX_OUT_COUNT_HIGH: sel = UECS_CNT_HIGH;
            default: sel = UECS_NONE;
         endcase
      end
      return sel;
   endfunction

   // configuration
   logic inDoubleBuffer;
   logic isoMode;
   logic dirPick;
   logic forceToggleFlip;
   logic fifoSplitEn;
   logic outDoubleBuffer;
   logic sofWaitOnEmpty;
   logic [1:0] irqEnable;
   // endpoint state
   logic inLoaded;
   logic sofHold;
   logic outHaltRequest;
   logic outWaiting;
   logic next_outWaiting;
   logic [COUNT_W-1:0] lenSlot [2];
   logic errSlot [2];
   logic wrPtr;
   logic rdPtr;
   // bus decode
   uecs_reg_t regSel;
   logic writeFire;
   logic [7:0] readMux;
   // slot counters
   logic [1:0] inCount;
   logic inRoom;
   logic inHasPkt;
   logic outRoom;
   logic outNotEmpty;
   // events
   logic inLoadWrite;
   logic inPop;
   logic outPktOk;
   logic outPush;
   logic outPop;
   logic stallNow;
   logic overrunEv;
   logic outEv;
   logic [FLAG_COUNT-1:0] setVec;
   logic [FLAG_COUNT-1:0] clrVec;
   logic [FLAG_COUNT-1:0] flags;
   logic inLoadedRead;
   logic crcRead;
   logic [COUNT_W-1:0] headLen;

   // apb: zero wait states while ce is high, unmapped or misaligned answers with an error
   assign regSel = uecs_decode(paddr);
   assign pready = ce;
   assign pslverr = psel & penable & (regSel == UECS_NONE);
   assign writeFire = psel & penable & pwrite & ce & (regSel != UECS_NONE);
   // configuration registers
   always_ff @(posedge clk) begin
      if (rst) begin
         inDoubleBuffer <= REG_RESET[IN_DBL_BIT];
         isoMode <= REG_RESET[ISO_BIT];
         dirPick <= REG_RESET[DIR_BIT];
         forceToggleFlip <= REG_RESET[FORCE_TGL_BIT];
         fifoSplitEn <= REG_RESET[SPLIT_BIT];
      end else if (writeFire && regSel == UECS_IN_HIGH) begin
         inDoubleBuffer <= pwdata[IN_DBL_BIT];
         isoMode <= pwdata[ISO_BIT];
         dirPick <= pwdata[DIR_BIT];
         forceToggleFlip <= pwdata[FORCE_TGL_BIT];
         fifoSplitEn <= pwdata[SPLIT_BIT];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         outDoubleBuffer <= REG_RESET[OUT_DBL_BIT];
      end else if (writeFire && regSel == UECS_OUT_HIGH) begin
         outDoubleBuffer <= pwdata[OUT_DBL_BIT];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         sofWaitOnEmpty <= REG_RESET[SOF_WAIT_BIT];
         irqEnable <= REG_RESET[1:0];
      end else if (writeFire && regSel == UECS_OPTIONS) begin
         sofWaitOnEmpty <= pwdata[SOF_WAIT_BIT];
      end else if (writeFire && regSel == UECS_IRQ_ENABLE) begin
         irqEnable <= pwdata[1:0];
      end
   end
   // direction and split
   assign fifoSplit = fifoSplitEn;
   assign inDirActive = fifoSplitEn | dirPick;
   assign outDirActive = fifoSplitEn | ~dirPick;
   // in endpoint
   assign inLoadWrite = writeFire & (regSel == UECS_IN_LOW) & pwdata[IN_LOADED_BIT] & inRoom;
   assign inPop = inPktSent & inHasPkt;

   uecs_slot_counter u_in_slots (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .dual(inDoubleBuffer),
      .push(inLoadWrite),
      .pop(inPop),
      .count(inCount),
      .hasRoom(inRoom),
      .notEmpty(inHasPkt)
   );

   always_ff @(posedge clk) begin
      if (rst) begin
         inLoaded <= 1'b0;
      end else if (ce) begin
         if (inLoadWrite) begin
            // with a second slot still free the flag drops at once
            inLoaded <= ~(inDoubleBuffer & (inCount == 2'h0));
         end else if (inPop) begin
            inLoaded <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         sofHold <= 1'b0;
      end else if (ce) begin
         if (inLoadWrite && isoMode && sofWaitOnEmpty) begin
            sofHold <= 1'b1;
         end else if (sofRcvd) begin
            sofHold <= 1'b0;
         end
      end
   end

   assign inLoadedRead = inLoaded & ~sofHold;
   assign inPktReady = inHasPkt & ~sofHold & inDirActive;

   always_ff @(posedge clk) begin
      if (rst) begin
         inToggle <= 1'b0;
      end else if (ce) begin
         if (writeFire && regSel == UECS_IN_LOW && pwdata[IN_CLR_TOGGLE_BIT]) begin
            inToggle <= 1'b0;
         end else if (forceToggleFlip ? inPop : inAckRcvd) begin
            inToggle <= ~inToggle;
         end
      end
   end
   // out endpoint
   assign stallNow = outToken & outHaltRequest & outDirActive;
   assign outStall = stallNow;
   assign outPktOk = outPktValid & ~outHaltRequest & outDirActive;
   assign outPush = outPktOk & outRoom;
   assign outAccept = outRoom & ~outHaltRequest;
   assign overrunEv = outPktOk & ~outRoom & isoMode;
   assign outPop = writeFire & (regSel == UECS_OUT_LOW) & outNotEmpty
      & ((outWaiting & ~pwdata[OUT_WAITING_BIT]) | pwdata[OUT_FLUSH_BIT]);

   uecs_slot_counter u_out_slots (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .dual(outDoubleBuffer),
      .push(outPush),
      .pop(outPop),
      .count(),
      .hasRoom(outRoom),
      .notEmpty(outNotEmpty)
   );

   // a release followed by a queued packet re-raises the flag a cycle later
   always_comb begin
      next_outWaiting = outWaiting;
      if (outPop) begin
         next_outWaiting = 1'b0;
      end else if (outNotEmpty) begin
         next_outWaiting = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         outWaiting <= 1'b0;
      end else if (ce) begin
         outWaiting <= next_outWaiting;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wrPtr <= 1'b0;
         lenSlot[0] <= '0;
         lenSlot[1] <= '0;
         errSlot[0] <= 1'b0;
         errSlot[1] <= 1'b0;
      end else if (ce && outPush) begin
         lenSlot[wrPtr] <= outPktLen;
         errSlot[wrPtr] <= outPktCrcErr & isoMode;
         wrPtr <= ~wrPtr;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rdPtr <= 1'b0;
      end else if (ce && outPop) begin
         rdPtr <= ~rdPtr;
      end
   end

   assign headLen = outNotEmpty ? lenSlot[rdPtr] : '0;
   assign crcRead = outWaiting & errSlot[rdPtr];

   always_ff @(posedge clk) begin
      if (rst) begin
         outHaltRequest <= 1'b0;
      end else if (writeFire && regSel == UECS_OUT_LOW) begin
         outHaltRequest <= pwdata[OUT_HALT_REQ_BIT];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         outToggle <= 1'b0;
      end else if (ce) begin
         if (writeFire && regSel == UECS_OUT_LOW && pwdata[OUT_CLR_TOGGLE_BIT]) begin
            outToggle <= 1'b0;
         end else if (outPush) begin
            outToggle <= ~outToggle;
         end
      end
   end
   // sticky flags and pending interrupts
   assign outEv = (next_outWaiting & ~outWaiting) | stallNow | overrunEv;

   always_comb begin
      setVec = '0;
      clrVec = '0;
      setVec[FLAG_HALT_SENT] = stallNow;
      setVec[FLAG_NO_ROOM] = overrunEv;
      setVec[FLAG_IN_PEND] = inPop;
      setVec[FLAG_OUT_PEND] = outEv;
      if (writeFire && regSel == UECS_OUT_LOW) begin
         clrVec[FLAG_HALT_SENT] = ~pwdata[OUT_HALT_SENT_BIT];
         clrVec[FLAG_NO_ROOM] = ~pwdata[OUT_NO_ROOM_BIT];
      end
      if (writeFire && regSel == UECS_IRQ_STATUS) begin
         clrVec[FLAG_IN_PEND] = pwdata[IRQ_IN_BIT];
         clrVec[FLAG_OUT_PEND] = pwdata[IRQ_OUT_BIT];
      end
   end

   uecs_sticky_flags u_flags (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .setVec(setVec),
      .clrVec(clrVec),
      .flags(flags)
   );
   assign inIrq = flags[FLAG_IN_PEND] & irqEnable[IRQ_IN_BIT];
   assign outIrq = flags[FLAG_OUT_PEND] & irqEnable[IRQ_OUT_BIT];
   // read path, sampled in the setup cycle
   always_comb begin
      readMux = 8'h00;
      case (regSel)
         UECS_IRQ_STATUS: readMux = {6'h00, flags[FLAG_OUT_PEND], flags[FLAG_IN_PEND]};
         UECS_IRQ_ENABLE: readMux = {6'h00, irqEnable};
         UECS_OPTIONS: readMux = {7'h00, sofWaitOnEmpty};
         UECS_IN_LOW: readMux = {6'h00, inHasPkt, inLoadedRead};
         UECS_IN_HIGH: readMux = {inDoubleBuffer, isoMode, dirPick, 1'b0,
            forceToggleFlip, fifoSplitEn, 2'h0};
         UECS_OUT_LOW: readMux = {1'b0, flags[FLAG_HALT_SENT], outHaltRequest, 1'b0,
            crcRead, flags[FLAG_NO_ROOM], ~outRoom, outWaiting};
         UECS_OUT_HIGH: readMux = {outDoubleBuffer, isoMode, 6'h00};
         UECS_CNT_LOW: readMux = headLen[7:0];
         UECS_CNT_HIGH: readMux = {6'h00, headLen[COUNT_W-1:8]};
         default: readMux = 8'h00;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         prdata <= 32'h00000000;
      end else if (ce && psel && !penable && !pwrite) begin
         prdata <= {24'h000000, readMux};
      end
   end
endmodule // uecs_top
`default_nettype wire

/* usb_endpoint_ctrl_status_tb.sv */
`default_nettype none
module usb_endpoint_ctrl_status_tb;
   import uecs_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [5:0] IS = IDX_IRQ_STATUS;
   localparam logic [5:0] IE = IDX_IRQ_ENABLE;
   localparam logic [5:0] OP = IDX_EP_OPTIONS;
   localparam logic [5:0] IL = IDX_IN_CTRL_LOW;
   localparam logic [5:0] IH = IDX_IN_CTRL_HIGH;
   localparam logic [5:0] OL = IDX_OUT_CTRL_LOW;
   localparam logic [5:0] OH = IDX_OUT_CTRL_HIGH;
   localparam logic [5:0] CL = IDX_OUT_COUNT_LOW;
   localparam logic [5:0] CH = IDX_OUT_COUNT_HIGH;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata, rdData;
   logic pready, pslverr, rdErr, inPktSent, inAckRcvd, sofRcvd, inPktReady, inToggle;
   logic outToken, outPktValid, outPktCrcErr, outStall, outAccept, outToggle;
   logic inDirActive, outDirActive, fifoSplit, inIrq, outIrq;
   logic [COUNT_W-1:0] outPktLen;
   int errorCnt = 0;
   int samplesChecked = 0;
   always #10 clk = ~clk;
   uecs_top DUT (.clk, .rst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .inPktSent, .inAckRcvd, .sofRcvd, .inPktReady, .inToggle, .outToken,
      .outPktValid, .outPktLen, .outPktCrcErr, .outStall, .outAccept, .outToggle, .inDirActive,
      .outDirActive, .fifoSplit, .inIrq, .outIrq);
   uecs_host_model HOST (.clk, .inPktSent, .inAckRcvd, .sofRcvd, .outToken, .outPktValid,
      .outPktLen, .outPktCrcErr, .outStall);
   task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
      samplesChecked++;
      if (seen !== exp) begin
         errorCnt++;
         $display("[ERR] t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic [5:0] idx, input logic wr, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 100);
      rdData = prdata;
      rdErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic giveVerdict();
      $display("comparisons %0d mismatches %0d", samplesChecked, errorCnt);
      if (errorCnt == 0 && samplesChecked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic testRegs();
      apb(IH, 0, 0);
      chk(rdData, 0);
      apb(IH, 1, 32'hff);
      apb(IH, 0, 0);
      chk(rdData, 32'hec);
      chk({inDirActive, outDirActive, fifoSplit}, 3'b111);
      apb(IH, 1, 32'h20);
      chk({inDirActive, outDirActive, fifoSplit}, 3'b100);
      apb(IH, 1, 0);
      chk({inDirActive, outDirActive}, 2'b01);
      apb(6'h3f, 0, 0);
      chk({rdErr, rdData}, 33'h100000000);
      $display("register test done");
   endtask
   task automatic testIn();
      apb(IE, 1, 32'h3);
      apb(IH, 1, 32'h20);
      apb(IL, 1, 32'h1);
      apb(IL, 0, 0);
      chk({inPktReady, rdData}, 33'h100000003);
      HOST.inEvt(1, 0, 0);
      idle(2);
      chk({inIrq, inToggle}, 2'b10);
      apb(IL, 0, 0);
      chk(rdData, 0);
      apb(IS, 1, 32'h1);
      chk(inIrq, 0);
      HOST.inEvt(0, 1, 0);
      idle(1);
      chk(inToggle, 1);
      apb(IE, 1, 0);
      apb(IH, 1, 32'h28);
      apb(IL, 1, 32'h1);
      HOST.inEvt(1, 0, 0);
      idle(2);
      chk({inIrq, inToggle}, 2'b00);
      apb(IE, 1, 32'h3);
      chk(inIrq, 1);
      apb(IS, 1, 32'h1);
      apb(IH, 1, 32'ha0);
      apb(IL, 1, 32'h1);
      apb(IL, 0, 0);
      chk(rdData, 32'h2);
      apb(IL, 1, 32'h1);
      apb(IL, 0, 0);
      chk(rdData, 32'h3);
      HOST.inEvt(1, 0, 0);
      HOST.inEvt(1, 0, 0);
      apb(IS, 1, 32'h1);
      $display("in endpoint test done");
   endtask
   task automatic testSof();
      apb(OP, 1, 32'h1);
      apb(IH, 1, 32'h60);
      apb(IL, 1, 32'h1);
      apb(IL, 0, 0);
      chk({inPktReady, rdData[1:0]}, 3'b010);
      HOST.inEvt(0, 0, 1);
      idle(1);
      chk(inPktReady, 1);
      HOST.inEvt(1, 0, 0);
      apb(IS, 1, 32'h1);
      apb(OP, 1, 0);
      $display("frame wait test done");
   endtask
   task automatic testHold();
      @(posedge clk);
      ce <= 1'b0;
      HOST.inEvt(0, 1, 0);
      idle(1);
      chk(inToggle, 0);
      @(posedge clk);
      ce <= 1'b1;
      HOST.inEvt(0, 1, 0);
      idle(1);
      chk(inToggle, 1);
      $display("clock enable test done");
   endtask
   task automatic testBulk();
      apb(IH, 1, 0);
      apb(OH, 1, 32'h80);
      HOST.outPkt(10'h155, 0);
      HOST.outPkt(10'h0a3, 0);
      idle(2);
      chk(outIrq, 1);
      apb(OL, 0, 0);
      chk(rdData, 32'h3);
      apb(CL, 0, 0);
      chk(rdData, 32'h55);
      apb(CH, 0, 0);
      chk(rdData, 32'h1);
      apb(IS, 1, 32'h2);
      chk(outIrq, 0);
      apb(OL, 1, 32'h44);
      idle(3);
      chk(outIrq, 1);
      apb(OL, 0, 0);
      chk(rdData, 32'h1);
      apb(CL, 0, 0);
      chk(rdData, 32'ha3);
      apb(OL, 1, 32'h44);
      apb(IS, 1, 32'h2);
      apb(OL, 0, 0);
      chk(rdData, 0);
      $display("bulk out test done");
   endtask
   task automatic testStall();
      apb(OL, 1, 32'h64);
      HOST.outPkt(10'h10, 0);
      idle(2);
      chk(HOST.stallCnt, 1);
      chk({outIrq, outAccept}, 2'b10);
      apb(OL, 0, 0);
      chk(rdData, 32'h60);
      apb(OL, 1, 32'h04);
      apb(OL, 0, 0);
      chk({outAccept, rdData}, 33'h100000000);
      apb(IS, 1, 32'h2);
      $display("stall test done");
   endtask
   task automatic testIso();
      apb(OH, 1, 0);
      apb(IH, 1, 32'h40);
      HOST.outPkt(10'h20, 1);
      idle(2);
      chk(outIrq, 1);
      chk(outToggle, 1);
      apb(OL, 0, 0);
      chk(rdData & 32'hd, 32'h9);
      HOST.outPkt(10'h21, 0);
      idle(2);
      apb(OL, 0, 0);
      chk(rdData & 32'hd, 32'hd);
      apb(OL, 1, 32'h40);
      apb(OL, 0, 0);
      chk(rdData & 32'hd, 0);
      HOST.outPkt(10'h22, 0);
      idle(2);
      apb(OL, 0, 0);
      chk(rdData & 32'hd, 32'h1);
      apb(OL, 1, 32'h40);
      apb(IS, 1, 32'h2);
      $display("iso out test done");
   endtask
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      testRegs();
      testIn();
      testSof();
      testHold();
      testBulk();
      testStall();
      testIso();
      giveVerdict();
   end
   // the sequence needs well under a thousand cycles
   initial begin
      #100000;
      errorCnt++;
      giveVerdict();
   end
endmodule // usb_endpoint_ctrl_status_tb
bind uecs_top uecs_monitor MON (.clk, .rst, .psel, .penable, .pwrite, .inPktSent, .inAckRcvd,
   .inPktReady, .inToggle, .outToken, .outPktValid, .outStall, .outAccept, .inDirActive,
   .outDirActive, .fifoSplit, .inIrq, .outIrq);
`default_nettype wire
